// >>> rtl/sldc_params.svh
`ifndef SLDC_PARAMS_SVH
`define SLDC_PARAMS_SVH

// register offsets, byte address equals printed offset
`define SLDC_OFF_DBG_T0 8'h10
`define SLDC_OFF_DBG_T1 8'h11
`define SLDC_OFF_ORIGIN 8'h1f
`define SLDC_OFF_EXTERNAL_SWITCH_LINK 8'h20
`define SLDC_OFF_PROCESSOR_LINK 8'h40
`define SLDC_OFF_XCFG 8'h80
`define SLDC_OFF_STATIC 8'ha0
`define SLDC_NLINK 8

// debug pin configuration fields
`define SLDC_DBG_DRIVE_BIT 0
`define SLDC_DBG_REQ_BIT 1
// halt event origin fields
`define SLDC_ORG_CORE0_BIT 0
`define SLDC_ORG_CORE1_BIT 1
`define SLDC_ORG_PIN_BIT 4

// link status fields
`define SLDC_ST_SRC_BIT 0
`define SLDC_ST_DST_BIT 1
`define SLDC_ST_JUNK_BIT 2
`define SLDC_ST_NET_LSB 4
`define SLDC_ST_DIR_LSB 8
`define SLDC_ST_DEST_LSB 16
`define SLDC_ST_TYPE_LSB 24

// external link configuration fields
`define SLDC_XC_TOKGAP_LSB 0
`define SLDC_XC_SYMGAP_LSB 11
`define SLDC_XC_RXRST_BIT 23
`define SLDC_XC_GREETING_TOKEN_BIT 24
`define SLDC_XC_HAVECR_BIT 25
`define SLDC_XC_GAVECR_BIT 26
`define SLDC_XC_ERR_BIT 27
`define SLDC_XC_WIDE_BIT 30
`define SLDC_XC_EN_BIT 31

// static forwarding fields
`define SLDC_SF_CHAN_LSB 0
`define SLDC_SF_PROC_BIT 8
`define SLDC_SF_EN_BIT 31

// reset values
`define SLDC_RST_DBG 2'h0
`define SLDC_RST_NET 2'h0
`define SLDC_RST_DIR 4'h0
`define SLDC_RST_GAP 11'h000

`endif

// >>> rtl/sldc_pkg.sv
package sldc_pkg;

    // endpoint type reported in link status
    typedef enum logic [1:0] {
        SLDC_EP_SWITCH_LINK = 2'b00,
        SLDC_EP_PROC_LINK = 2'b01,
        SLDC_EP_SWITCH_CTRL = 2'b10,
        SLDC_EP_UNDEF = 2'b11
    } sldc_ep_e;

    // live status of one link from the router fabric
    typedef struct packed {
        sldc_ep_e ep_type;
        logic [7:0] dest;
        logic junk;
        logic dst_busy;
        logic src_busy;
    } sldc_link_stat_s;

    // events from one external link's physical layer
    typedef struct packed {
        logic rx_error;
        logic credit_issued;
        logic credit_received;
        logic credit_issued_clr;
    } sldc_xlink_ev_s;

    // one transmit symbol request
    typedef struct packed {
        logic valid;
        logic last;
    } sldc_tx_req_s;

    // static forwarding setting as used by the router
    typedef struct packed {
        logic enable;
        logic proc;
        logic [4:0] chan;
    } sldc_static_s;

    typedef logic [10:0] sldc_gap_t;

endpackage

// >>> rtl/sldc_top.sv
`timescale 1ns/1ps
`include "sldc_params.svh"
// How it works
// - tile halt request follows shared halt when enabled
// - core halt drives shared halt when enabled
// - origin register records last halt source
// - status bits 25:24 give endpoint type
// - status bits 23:16 give destination link
// - switch-link direction field, writable, resets zero
// - network field bits 5:4, writable, resets zero
// - status bit 2 flags junk packet
// - bits 1/0 show dest/source side busy
// - processor-link status registers, no direction field
// - bit 31 enables link, selects pin mux
// - bit 30 selects 5-wire, resets 2-wire
// - bit 27 flags overflow or illegal token
// - bits 26/25 report issued and held credit
// - bit 24 write clears credit, sends greeting
// - bit 23 write resets link receiver
// - symbol gap at least field plus one
// - token gap at least field plus one
// - static enable forwards link to channel end
// - static processor bit 8, channel bits 4:0
// - static registers map to links C,D,A,B,G,H,E,F
module sldc_top (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic [1:0] core_halted_in,
    input wire logic ext_halt_pin_in,
    output logic shared_halt_signal_out,
    output logic [1:0] debug_req_out,
    input wire sldc_pkg::sldc_link_stat_s [7:0] external_switch_link_stat_in,
    input wire sldc_pkg::sldc_link_stat_s [7:0] processor_link_stat_in,
    output logic [7:0][3:0] external_switch_link_dir_out,
    output logic [7:0][1:0] external_switch_link_net_out,
    output logic [7:0][1:0] processor_link_net_out,
    input wire sldc_pkg::sldc_xlink_ev_s [7:0] xlink_ev_in,
    output logic [7:0] xlink_enable_out,
    output logic [7:0] xlink_wide_out,
    output logic [7:0] greeting_token_out,
    output logic [7:0] rx_reset_out,
    input wire sldc_pkg::sldc_tx_req_s [7:0] tx_req_in,
    output logic [7:0] tx_ready_out,
    output sldc_pkg::sldc_static_s [7:0] static_by_link_out
);
    import sldc_pkg::*;

    // register file state
    logic [1:0] dbg_cfg_reg [2];
    logic [4:0] origin_reg;
    logic prev_halt_reg;
    logic [3:0] dir_reg [8];
    logic [1:0] snet_reg [8];
    logic [1:0] pnet_reg [8];
    logic [7:0] en_reg;
    logic [7:0] wide_reg;
    logic [7:0] err_reg;
    logic [7:0] gave_cr_reg;
    logic [7:0] have_cr_reg;
    logic [7:0] greeting_token_reg;
    logic [7:0] rxrst_reg;
    sldc_gap_t symgap_reg [8];
    sldc_gap_t tokgap_reg [8];
    logic [11:0] gapcnt_reg [8];
    sldc_static_s static_reg [8];
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // address decode
    wire logic [2:0] idx = addr_in[2:0];
    wire logic hit_dbg0 = addr_in == `SLDC_OFF_DBG_T0;
    wire logic hit_dbg1 = addr_in == `SLDC_OFF_DBG_T1;
    wire logic hit_org = addr_in == `SLDC_OFF_ORIGIN;
    wire logic hit_sl = addr_in[7:3] == 5'(`SLDC_OFF_EXTERNAL_SWITCH_LINK >> 3);
    wire logic hit_pl = addr_in[7:3] == 5'(`SLDC_OFF_PROCESSOR_LINK >> 3);
    wire logic hit_xc = addr_in[7:3] == 5'(`SLDC_OFF_XCFG >> 3);
    wire logic hit_sf = addr_in[7:3] == 5'(`SLDC_OFF_STATIC >> 3);
    wire logic wr_org = wr_in && hit_org;

    // shared halt: external pin or any enabled halted core
    wire logic core0_drive = core_halted_in[0] && dbg_cfg_reg[0][`SLDC_DBG_DRIVE_BIT];
    wire logic core1_drive = core_halted_in[1] && dbg_cfg_reg[1][`SLDC_DBG_DRIVE_BIT];
    wire logic halt_now = ext_halt_pin_in || core0_drive || core1_drive;
    wire logic halt_rise = halt_now && !prev_halt_reg;
    assign shared_halt_signal_out = halt_now;
    assign debug_req_out[0] = halt_now && dbg_cfg_reg[0][`SLDC_DBG_REQ_BIT];
    assign debug_req_out[1] = halt_now && dbg_cfg_reg[1][`SLDC_DBG_REQ_BIT];

    // debug pin configuration, one per tile
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            dbg_cfg_reg[0] <= `SLDC_RST_DBG;
            dbg_cfg_reg[1] <= `SLDC_RST_DBG;
        end else begin
            if (wr_in && hit_dbg0)
                dbg_cfg_reg[0] <= wdata_in[1:0];
            if (wr_in && hit_dbg1)
                dbg_cfg_reg[1] <= wdata_in[1:0];
        end
    end

    // origin of the latest halt event; a new event beats a software write
    logic [4:0] origin_new;
    assign origin_new = {ext_halt_pin_in, 2'b00, core1_drive, core0_drive};
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            origin_reg <= 5'h00;
            prev_halt_reg <= 1'b0;
        end else begin
            prev_halt_reg <= halt_now;
            if (halt_rise)
                origin_reg <= origin_new;
            else if (wr_org)
                origin_reg <= {wdata_in[4], 2'b00, wdata_in[1:0]};
        end
    end

    // static registers are ordered C,D,A,B,G,H,E,F; links A..H are 0..7
    localparam logic [2:0] STATIC_LINK [8] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h4, 3'h5};

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gen_link
            wire logic wr_sl = wr_in && hit_sl && idx == 3'(g);
            wire logic wr_pl = wr_in && hit_pl && idx == 3'(g);
            wire logic wr_xc = wr_in && hit_xc && idx == 3'(g);
            wire logic wr_sf = wr_in && hit_sf && idx == 3'(g);
            wire logic greeting_token_wr = wr_xc && wdata_in[`SLDC_XC_GREETING_TOKEN_BIT];
            wire logic rxrst_wr = wr_xc && wdata_in[`SLDC_XC_RXRST_BIT];
            // a symbol goes out only when enabled, paced and holding credit
            wire logic ready = en_reg[g] && have_cr_reg[g] && gapcnt_reg[g] == 12'h000;
            wire logic sent = ready && tx_req_in[g].valid;

            // switch and processor link fields
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    dir_reg[g] <= `SLDC_RST_DIR;
                    snet_reg[g] <= `SLDC_RST_NET;
                    pnet_reg[g] <= `SLDC_RST_NET;
                end else begin
                    if (wr_sl) begin
                        dir_reg[g] <= wdata_in[`SLDC_ST_DIR_LSB +: 4];
                        snet_reg[g] <= wdata_in[`SLDC_ST_NET_LSB +: 2];
                    end
                    if (wr_pl)
                        pnet_reg[g] <= wdata_in[`SLDC_ST_NET_LSB +: 2];
                end
            end

            // external link control; enable and width hold until rewritten
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    en_reg[g] <= 1'b0;
                    wide_reg[g] <= 1'b0;
                    symgap_reg[g] <= `SLDC_RST_GAP;
                    tokgap_reg[g] <= `SLDC_RST_GAP;
                end else if (wr_xc) begin
                    en_reg[g] <= wdata_in[`SLDC_XC_EN_BIT];
                    wide_reg[g] <= wdata_in[`SLDC_XC_WIDE_BIT];
                    symgap_reg[g] <= wdata_in[`SLDC_XC_SYMGAP_LSB +: 11];
                    tokgap_reg[g] <= wdata_in[`SLDC_XC_TOKGAP_LSB +: 11];
                end
            end

            // sticky error cleared by receiver reset; new error wins
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in)
                    err_reg[g] <= 1'b0;
                else if (xlink_ev_in[g].rx_error)
                    err_reg[g] <= 1'b1;
                else if (rxrst_wr)
                    err_reg[g] <= 1'b0;
            end

            // credit state; a greeting clears held credit unless credit lands now
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    gave_cr_reg[g] <= 1'b0;
                    have_cr_reg[g] <= 1'b0;
                end else begin
                    if (xlink_ev_in[g].credit_issued)
                        gave_cr_reg[g] <= 1'b1;
                    else if (xlink_ev_in[g].credit_issued_clr)
                        gave_cr_reg[g] <= 1'b0;
                    if (xlink_ev_in[g].credit_received)
                        have_cr_reg[g] <= 1'b1;
                    else if (greeting_token_wr)
                        have_cr_reg[g] <= 1'b0;
                end
            end

            // one-cycle command pulses to the link layer
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    greeting_token_reg[g] <= 1'b0;
                    rxrst_reg[g] <= 1'b0;
                end else begin
                    greeting_token_reg[g] <= greeting_token_wr;
                    rxrst_reg[g] <= rxrst_wr;
                end
            end

            // idle gap after each symbol: field plus one clocks
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in)
                    gapcnt_reg[g] <= 12'h000;
                else if (sent && tx_req_in[g].last)
                    gapcnt_reg[g] <= {1'b0, tokgap_reg[g]} + 12'h001;
                else if (sent)
                    gapcnt_reg[g] <= {1'b0, symgap_reg[g]} + 12'h001;
                else if (gapcnt_reg[g] != 12'h000)
                    gapcnt_reg[g] <= gapcnt_reg[g] - 12'h001;
            end

            // static forwarding settings
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in)
                    static_reg[g] <= '0;
                else if (wr_sf) begin
                    static_reg[g].enable <= wdata_in[`SLDC_SF_EN_BIT];
                    static_reg[g].proc <= wdata_in[`SLDC_SF_PROC_BIT];
                    static_reg[g].chan <= wdata_in[`SLDC_SF_CHAN_LSB +: 5];
                end
            end

            assign tx_ready_out[g] = ready;
            assign external_switch_link_dir_out[g] = dir_reg[g];
            assign external_switch_link_net_out[g] = snet_reg[g];
            assign processor_link_net_out[g] = pnet_reg[g];
            assign static_by_link_out[STATIC_LINK[g]] = static_reg[g];
        end
    endgenerate

    assign xlink_enable_out = en_reg;
    assign xlink_wide_out = wide_reg;
    assign greeting_token_out = greeting_token_reg;
    assign rx_reset_out = rxrst_reg;

    // status word shared by switch and processor links
    function automatic logic [31:0] stat_word(input sldc_link_stat_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`SLDC_ST_TYPE_LSB +: 2] = s.ep_type;
        w[`SLDC_ST_DEST_LSB +: 8] = s.dest;
        w[`SLDC_ST_JUNK_BIT] = s.junk;
        w[`SLDC_ST_DST_BIT] = s.dst_busy;
        w[`SLDC_ST_SRC_BIT] = s.src_busy;
        return w;
    endfunction

    // read mux; command bits and unmapped addresses read as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_dbg0)
            rdata_next[1:0] = dbg_cfg_reg[0];
        else if (hit_dbg1)
            rdata_next[1:0] = dbg_cfg_reg[1];
        else if (hit_org)
            rdata_next[4:0] = origin_reg;
        else if (hit_sl) begin
            rdata_next = stat_word(external_switch_link_stat_in[idx]);
            rdata_next[`SLDC_ST_DIR_LSB +: 4] = dir_reg[idx];
            rdata_next[`SLDC_ST_NET_LSB +: 2] = snet_reg[idx];
        end else if (hit_pl) begin
            rdata_next = stat_word(processor_link_stat_in[idx]);
            rdata_next[`SLDC_ST_NET_LSB +: 2] = pnet_reg[idx];
        end else if (hit_xc) begin
            rdata_next[`SLDC_XC_EN_BIT] = en_reg[idx];
            rdata_next[`SLDC_XC_WIDE_BIT] = wide_reg[idx];
            rdata_next[`SLDC_XC_ERR_BIT] = err_reg[idx];
            rdata_next[`SLDC_XC_GAVECR_BIT] = gave_cr_reg[idx];
            rdata_next[`SLDC_XC_HAVECR_BIT] = have_cr_reg[idx];
            rdata_next[`SLDC_XC_SYMGAP_LSB +: 11] = symgap_reg[idx];
            rdata_next[`SLDC_XC_TOKGAP_LSB +: 11] = tokgap_reg[idx];
        end else if (hit_sf) begin
            rdata_next[`SLDC_SF_EN_BIT] = static_reg[idx].enable;
            rdata_next[`SLDC_SF_PROC_BIT] = static_reg[idx].proc;
            rdata_next[`SLDC_SF_CHAN_LSB +: 5] = static_reg[idx].chan;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in)
            rdata_reg <= 32'h0000_0000;
        else
            rdata_reg <= rd_in ? rdata_next : 32'h0000_0000;
    end
    assign rdata_out = rdata_reg;

endmodule

// >>> testbench/sldc_top_properties.sv
`timescale 1ns/1ps
module sldc_top_properties (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic ext_halt_pin_in,
    input wire logic shared_halt_signal_out,
    input wire logic [1:0] debug_req_out,
    input wire logic [7:0][3:0] external_switch_link_dir_out,
    input wire logic [7:0][1:0] external_switch_link_net_out,
    input wire logic [7:0][1:0] processor_link_net_out,
    input wire logic [7:0] xlink_enable_out,
    input wire logic [7:0] xlink_wide_out,
    input wire logic [7:0] greeting_token_out,
    input wire logic [7:0] rx_reset_out,
    input wire sldc_pkg::sldc_tx_req_s [7:0] tx_req_in,
    input wire logic [7:0] tx_ready_out,
    input wire sldc_pkg::sldc_static_s [7:0] static_by_link_out
);
    import sldc_pkg::*;
    sldc_gap_t sym_reg;
    sldc_gap_t tok_reg;
    logic [11:0] hold_reg;
    logic [11:0] hold_next;
    // link 0 gaps mirrored from writes so the idle time after each symbol is known exactly
    wire take0 = tx_req_in[0].valid && tx_ready_out[0];
    wire xcfg0_wr = wr_in && addr_in == 8'h80;
    assign hold_next = take0 ? {1'b0, tx_req_in[0].last ? tok_reg : sym_reg} + 12'h001
                             : hold_reg - {11'h000, hold_reg != 12'h000};
    // short and local: a write landing with a send is not modelled
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sym_reg <= '0;
            tok_reg <= '0;
            hold_reg <= '0;
        end else begin
            if (xcfg0_wr) begin
                sym_reg <= wdata_in[21:11];
                tok_reg <= wdata_in[10:0];
            end
            hold_reg <= hold_next;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    chk_req_needs_halt: assert property (debug_req_out != 2'h0 |-> shared_halt_signal_out)
        else $error("debug request without shared halt");
    chk_pin_drives_halt: assert property (ext_halt_pin_in |-> shared_halt_signal_out)
        else $error("external pin did not raise shared halt");
    chk_link_enable_wr: assert property (wr_in && addr_in[7:3] == 5'h10 |=>
        xlink_enable_out[$past(addr_in[2:0])] == $past(wdata_in[31]))
        else $error("link enable did not follow write");
    chk_wire_mode_wr: assert property (wr_in && addr_in[7:3] == 5'h10 |=>
        xlink_wide_out[$past(addr_in[2:0])] == $past(wdata_in[30]))
        else $error("wire mode did not follow write");
    chk_greeting_pulse: assert property (wr_in && addr_in[7:3] == 5'h10 && wdata_in[24] |=>
        greeting_token_out[$past(addr_in[2:0])])
        else $error("greeting token missing after write");
    chk_rx_reset_pulse: assert property (wr_in && addr_in[7:3] == 5'h10 && wdata_in[23] |=>
        rx_reset_out[$past(addr_in[2:0])])
        else $error("receiver reset missing after write");
    chk_gap_hold_idle: assert property (hold_reg != 12'h000 |-> !tx_ready_out[0])
        else $error("transmit ready inside idle gap");
    chk_static_fields: assert property (wr_in && addr_in[7:3] == 5'h14 |=>
        static_by_link_out[$past(addr_in[2:0]) ^ 3'h2] == {$past(wdata_in[31]), $past(wdata_in[8]), $past(wdata_in[4:0])})
        else $error("static forwarding setting wrong link or value");
    chk_external_switch_link_dir_net: assert property (wr_in && addr_in[7:3] == 5'h04 |=>
        {external_switch_link_dir_out[$past(addr_in[2:0])], external_switch_link_net_out[$past(addr_in[2:0])]} == {$past(wdata_in[11:8]), $past(wdata_in[5:4])})
        else $error("switch link direction or network wrong");
    chk_processor_link_net: assert property (wr_in && addr_in[7:3] == 5'h08 |=>
        processor_link_net_out[$past(addr_in[2:0])] == $past(wdata_in[5:4]))
        else $error("processor link network wrong");
    cov_greeting: cover property (greeting_token_out[0]);
    cov_send_token: cover property (take0 && tx_req_in[0].last);
    cov_static_write: cover property (wr_in && addr_in[7:3] == 5'h14);
endmodule
bind sldc_top sldc_top_properties u_props (.clock_in, .rst_in, .addr_in, .wdata_in, .wr_in, .ext_halt_pin_in,
    .shared_halt_signal_out, .debug_req_out, .external_switch_link_dir_out, .external_switch_link_net_out, .processor_link_net_out, .xlink_enable_out,
    .xlink_wide_out, .greeting_token_out, .rx_reset_out, .tx_req_in, .tx_ready_out, .static_by_link_out);

// >>> testbench/sldc_remote_node.sv
`timescale 1ns/1ps
module sldc_remote_node (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [7:0] greeting_token_in,
    input wire logic [7:0] link_enable_in,
    input wire logic bad_token_in,
    input wire logic [3:0] reply_delay_in,
    output sldc_pkg::sldc_xlink_ev_s [7:0] xlink_ev_out
);
    import sldc_pkg::*;
    logic [7:0][3:0] wait_reg;
    logic [7:0][3:0] wait_next;
    // far end answers a greeting with credit after a settable delay; a delay of zero never answers
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            wait_next[i] = (wait_reg[i] != 4'h0) ? wait_reg[i] - 4'h1 : 4'h0;
            if (greeting_token_in[i] && link_enable_in[i]) begin
                wait_next[i] = reply_delay_in;
            end
            xlink_ev_out[i] = '0;
            xlink_ev_out[i].credit_received = (wait_reg[i] == 4'h1);
            // credit flows both ways once the greeting has been answered
            xlink_ev_out[i].credit_issued = (wait_reg[i] == 4'h1);
            xlink_ev_out[i].rx_error = bad_token_in && (i == 0); // corrupt tokens only when commanded
        end
    end
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wait_reg <= '0;
        end else begin
            wait_reg <= wait_next;
        end
    end
endmodule

// >>> testbench/sldc_top_bench.sv
`timescale 1ns/1ps
module sldc_top_bench;
    import sldc_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [31:0] rdata_out;
    logic [1:0] core_halted_in = 2'h0;
    logic ext_halt_pin_in = 1'b0;
    logic shared_halt_signal_out;
    logic [1:0] debug_req_out;
    sldc_link_stat_s [7:0] external_switch_link_stat_in = '0;
    sldc_link_stat_s [7:0] processor_link_stat_in = '0;
    logic [7:0][3:0] external_switch_link_dir_out;
    logic [7:0][1:0] external_switch_link_net_out;
    logic [7:0][1:0] processor_link_net_out;
    sldc_xlink_ev_s [7:0] xlink_ev_in;
    logic [7:0] xlink_enable_out;
    logic [7:0] xlink_wide_out;
    logic [7:0] greeting_token_out;
    logic [7:0] rx_reset_out;
    sldc_tx_req_s [7:0] tx_req_in = '0;
    logic [7:0] tx_ready_out;
    sldc_static_s [7:0] static_by_link_out;
    logic bad_token_in = 1'b0;
    logic [3:0] reply_delay_in = 4'h1;
    int n_errors = 0;
    int total_checks = 0;
    int greet_cnt = 0;
    int rxrst_cnt = 0;
    logic [7:0] reset_addrs [9] = '{8'h10, 8'h11, 8'h1f, 8'h20, 8'h40, 8'h47, 8'h80, 8'ha0, 8'h30};
    sldc_top DUT (.clock_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .core_halted_in,
        .ext_halt_pin_in, .shared_halt_signal_out, .debug_req_out, .external_switch_link_stat_in, .processor_link_stat_in, .external_switch_link_dir_out,
        .external_switch_link_net_out, .processor_link_net_out, .xlink_ev_in, .xlink_enable_out, .xlink_wide_out, .greeting_token_out,
        .rx_reset_out, .tx_req_in, .tx_ready_out, .static_by_link_out);
    sldc_remote_node u_remote (.clock_in, .rst_in, .greeting_token_in(greeting_token_out),
        .link_enable_in(xlink_enable_out), .bad_token_in, .reply_delay_in, .xlink_ev_out(xlink_ev_in));
    always #12.5 clock_in = ~clock_in;
    // pulses last one cycle, so they are counted here rather than sampled after each access
    always @(negedge clock_in) begin
        if (greeting_token_out[0] === 1'b1) greet_cnt++;
        if (rx_reset_out[0] === 1'b1) rxrst_cnt++;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(negedge clock_in);
        check(rdata_out, exp);
        @(posedge clock_in);
    endtask
    // waits for ready under a bound, sends one symbol, then counts idle cycles until ready returns
    task automatic send(input logic last, input int gap);
        int n;
        n = 0;
        tx_req_in[0] <= '{valid: 1'b1, last: last};
        @(negedge clock_in);
        while (tx_ready_out[0] !== 1'b1 && n < 60) begin
            n++;
            @(negedge clock_in);
        end
        @(posedge clock_in);
        tx_req_in[0] <= '0;
        n = 0;
        @(negedge clock_in);
        while (tx_ready_out[0] !== 1'b1 && n < 60) begin
            n++;
            @(negedge clock_in);
        end
        check(n, gap + 1);
        @(posedge clock_in);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // whole run is well under a thousand cycles
    initial begin
        #(25 * 5000);
        n_errors++;
        $display("watchdog expired");
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        reg_wr(8'h30, 32'hffff_ffff);
        foreach (reset_addrs[k]) rd_chk(reset_addrs[k], 32'h0000_0000);
        $display("test reset values done");
        reg_wr(8'h10, 32'hffff_ffff);
        rd_chk(8'h10, 32'h0000_0003);
        core_halted_in <= 2'h1;
        @(negedge clock_in);
        check({29'h0, shared_halt_signal_out, debug_req_out}, 32'h0000_0005);
        @(posedge clock_in);
        core_halted_in <= 2'h0;
        rd_chk(8'h1f, 32'h0000_0001);
        ext_halt_pin_in <= 1'b1;
        @(posedge clock_in);
        ext_halt_pin_in <= 1'b0;
        rd_chk(8'h1f, 32'h0000_0010);
        reg_wr(8'h11, 32'h0000_0003);
        core_halted_in <= 2'h2;
        @(negedge clock_in);
        check({29'h0, shared_halt_signal_out, debug_req_out}, 32'h0000_0007);
        @(posedge clock_in);
        core_halted_in <= 2'h0;
        rd_chk(8'h1f, 32'h0000_0002);
        reg_wr(8'h1f, 32'hffff_ffff);
        rd_chk(8'h1f, 32'h0000_0013);
        reg_wr(8'h10, 32'h0000_0000);
        core_halted_in <= 2'h1;
        @(negedge clock_in);
        check({29'h0, shared_halt_signal_out, debug_req_out}, 32'h0000_0000);
        @(posedge clock_in);
        core_halted_in <= 2'h0;
        $display("test halt routing done");
        for (int i = 0; i < 8; i++) begin
            external_switch_link_stat_in[i] <= sldc_link_stat_s'({i[1:0], 8'h5a, i[2:0]});
            processor_link_stat_in[i] <= sldc_link_stat_s'({i[1:0], 8'ha5, i[2:0]});
            reg_wr(8'h20 + 8'(i), 32'hffff_ffff);
            reg_wr(8'h40 + 8'(i), 32'hffff_ffff);
            rd_chk(8'h20 + 8'(i), {6'h00, i[1:0], 8'h5a, 8'h0f, 4'h3, 1'b0, i[2:0]});
            rd_chk(8'h40 + 8'(i), {6'h00, i[1:0], 8'ha5, 8'h00, 4'h3, 1'b0, i[2:0]});
            check({24'h0, external_switch_link_dir_out[i], external_switch_link_net_out[i], processor_link_net_out[i]}, 32'h0000_00ff);
        end
        $display("test link status done");
        reg_wr(8'h80, 32'hc000_0802);
        rd_chk(8'h80, 32'hc000_0802);
        check({30'h0, xlink_enable_out[0], xlink_wide_out[0]}, 32'h0000_0003);
        reg_wr(8'h80, 32'hc100_0802);
        send(1'b0, 1);
        send(1'b1, 2);
        rd_chk(8'h80, 32'hc600_0802);
        reply_delay_in <= 4'h9;
        reg_wr(8'h80, 32'hc100_0802);
        rd_chk(8'h80, 32'hc400_0802);
        send(1'b1, 2);
        bad_token_in <= 1'b1;
        @(posedge clock_in);
        bad_token_in <= 1'b0;
        rd_chk(8'h80, 32'hce00_0802);
        reg_wr(8'h80, 32'hc080_0802);
        rd_chk(8'h80, 32'hc600_0802);
        check(greet_cnt, 2);
        check(rxrst_cnt, 1);
        reg_wr(8'h80, 32'h4000_0802);
        tx_req_in[0] <= '{valid: 1'b1, last: 1'b1};
        @(negedge clock_in);
        check({30'h0, xlink_enable_out[0], tx_ready_out[0]}, 32'h0000_0000);
        @(posedge clock_in);
        tx_req_in[0] <= '0;
        $display("test external link done");
        for (int i = 0; i < 8; i++) begin
            reg_wr(8'ha0 + 8'(i), 32'hffff_ffe0 | 32'(i));
            rd_chk(8'ha0 + 8'(i), 32'h8000_0100 | 32'(i));
            check({25'h0, static_by_link_out[i ^ 2]}, 32'h0000_0060 | 32'(i));
        end
        $display("test static forwarding done");
        print_verdict();
    end
endmodule
